// ---- inc/rtm_pkg.sv ----
// constants and types shared by the ram timing host controller
package rtm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 10;
  // write timing figures, ns
  localparam int T_SU_ADDR_NS = 20;
  localparam int T_SU_DATA_NS = 20;
  localparam int T_WE_HI_NS = 30;
  localparam int T_HOLD_ADDR_NS = 10;
  localparam int T_HOLD_DATA_NS = 10;
  localparam int T_WE_LO_NS = 30;
  // read path delay, ns; the device default is zero, so allow one settle cycle
  localparam int T_RD_DLY_NS = 0;
  // minimum times round up, never below one cycle
  function automatic int min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int SU_CYC = min_cycles((T_SU_ADDR_NS > T_SU_DATA_NS) ? T_SU_ADDR_NS
                                                                     : T_SU_DATA_NS);
  localparam int HI_CYC = min_cycles(T_WE_HI_NS);
  localparam int HOLD_CYC = min_cycles((T_HOLD_ADDR_NS > T_HOLD_DATA_NS) ? T_HOLD_ADDR_NS
                                                                          : T_HOLD_DATA_NS);
  localparam int LO_CYC = min_cycles(T_WE_LO_NS);
  localparam int RD_CYC = min_cycles(T_RD_DLY_NS);
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WHI, ST_HOLD, ST_WLO, ST_RDLY, ST_RDONE}
    rtm_state_t;
endpackage

// ---- inc/rtm_tmr_if.sv ----
// interface between the sequencer and its phase timer
`timescale 1ns/1ps
interface rtm_tmr_if;
  logic load;
  logic [rtm_pkg::CNT_W-1:0] count;
  logic done;
  modport ctl(output load, output count, input done);
  modport tmr(input load, input count, output done);
endinterface

// ---- rtl/rtm_host.sv ----
// host controller driving the ram timing model's write and read sections
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module rtm_host (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_req_i,
  input wire logic rd_req_i,
  input wire logic [rtm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rtm_pkg::DATA_W-1:0] wdata_i,
  input wire logic [rtm_pkg::DATA_W-1:0] ram_rdata_i,
  output logic busy_o,
  output logic rd_valid_o,
  output logic [rtm_pkg::DATA_W-1:0] rdata_o,
  output logic [rtm_pkg::ADDR_W-1:0] ram_addr_o,
  output logic [rtm_pkg::DATA_W-1:0] ram_wdata_o,
  output logic ram_we_o,
  output logic ram_re_o
);
  rtm_tmr_if tif();
  rtm_timer u_tmr (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .t(tif.tmr)
  );
  //////////////////////////////////////////////////////////////////////////////
  // read data comes from the device pins, so it is synchronised
  logic [rtm_pkg::DATA_W-1:0] rd_meta;
  logic [rtm_pkg::DATA_W-1:0] rd_sync;
  always_ff @(posedge ref_clk_i) begin
    rd_meta <= ram_rdata_i;
    rd_sync <= rd_meta;
  end
  //////////////////////////////////////////////////////////////////////////////
  rtm_pkg::rtm_state_t st;
  rtm_pkg::rtm_state_t next_st;
  logic [rtm_pkg::CNT_W-1:0] load_val;
  logic load;
  wire dn = tif.done;
  // two sync stages added to read settle so sampled data is current
  localparam logic [rtm_pkg::CNT_W-1:0] RD_WAIT = rtm_pkg::CNT_W'(rtm_pkg::RD_CYC + 2);
  always_comb begin
    next_st = st;
    load = 1'b0;
    load_val = rtm_pkg::CNT_ZERO;
    case (st)
      rtm_pkg::ST_IDLE: begin
        if (wr_req_i) begin
          next_st = rtm_pkg::ST_SETUP;
          load = 1'b1;
          load_val = rtm_pkg::CNT_W'(rtm_pkg::SU_CYC - 1);
        end else if (rd_req_i) begin
          next_st = rtm_pkg::ST_RDLY;
          load = 1'b1;
          load_val = RD_WAIT - 8'h01;
        end
      end
      rtm_pkg::ST_SETUP: if (dn) begin
        next_st = rtm_pkg::ST_WHI;
        load = 1'b1;
        load_val = rtm_pkg::CNT_W'(rtm_pkg::HI_CYC - 1);
      end
      rtm_pkg::ST_WHI: if (dn) begin
        next_st = rtm_pkg::ST_HOLD;
        load = 1'b1;
        load_val = rtm_pkg::CNT_W'(rtm_pkg::HOLD_CYC - 1);
      end
      rtm_pkg::ST_HOLD: if (dn) begin
        next_st = rtm_pkg::ST_WLO;
        load = 1'b1;
        load_val = rtm_pkg::CNT_W'(rtm_pkg::LO_CYC - 1);
      end
      rtm_pkg::ST_WLO: if (dn) begin
        next_st = rtm_pkg::ST_IDLE;
      end
      rtm_pkg::ST_RDLY: if (dn) begin
        next_st = rtm_pkg::ST_RDONE;
      end
      rtm_pkg::ST_RDONE: next_st = rtm_pkg::ST_IDLE;
      default: next_st = rtm_pkg::ST_IDLE;
    endcase
  end
  assign tif.load = load;
  assign tif.count = load_val;
  wire take = (st == rtm_pkg::ST_IDLE) & (wr_req_i | rd_req_i);
  wire we_next = (next_st == rtm_pkg::ST_WHI);
  wire re_next = (next_st == rtm_pkg::ST_RDLY) | (next_st == rtm_pkg::ST_RDONE);
  wire sample = (st == rtm_pkg::ST_RDLY) & dn;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= rtm_pkg::ST_IDLE;
    end else begin
      st <= next_st;
    end
  end
  // address and data latched once per access and frozen to the end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ram_addr_o <= 8'h00;
      ram_wdata_o <= 8'h00;
    end else if (take) begin
      ram_addr_o <= addr_i;
      ram_wdata_o <= wdata_i;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ram_we_o <= 1'b0;
      ram_re_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      ram_we_o <= we_next;
      ram_re_o <= re_next;
      busy_o <= (next_st != rtm_pkg::ST_IDLE);
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      rd_valid_o <= sample;
      if (sample) begin
        rdata_o <= rd_sync;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  property p_setup_before_we;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(ram_we_o) |-> $stable(ram_addr_o) && $stable(ram_wdata_o) && $past(busy_o);
  endproperty
  a_setup_before_we: assert property (p_setup_before_we) else $error("we rose without setup");
  property p_we_width;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(ram_we_o) |-> ram_we_o [*3];
  endproperty
  a_we_width: assert property (p_we_width) else $error("we high too short");
  property p_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      $fell(ram_we_o) |-> $stable(ram_addr_o) && $stable(ram_wdata_o) ##1
        $stable(ram_addr_o) && $stable(ram_wdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("address or data moved in hold");
  property p_we_low;
    @(posedge ref_clk_i) disable iff (rst_i)
      $fell(ram_we_o) |-> !ram_we_o [*4];
  endproperty
  a_we_low: assert property (p_we_low) else $error("we low too short");
  property p_rd_sample;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(ram_re_o) |-> ##3 rd_valid_o;
  endproperty
  a_rd_sample: assert property (p_rd_sample) else $error("read not sampled on time");
  property p_re_drop;
    @(posedge ref_clk_i) disable iff (rst_i)
      rd_valid_o |-> ram_re_o ##1 !ram_re_o;
  endproperty
  a_re_drop: assert property (p_re_drop) else $error("read enable not released");
  property p_addr_in_read;
    @(posedge ref_clk_i) disable iff (rst_i)
      ram_re_o && $past(ram_re_o) |-> $stable(ram_addr_o);
  endproperty
  a_addr_in_read: assert property (p_addr_in_read) else $error("address moved in read");
  property p_excl;
    @(posedge ref_clk_i) disable iff (rst_i)
      !(ram_we_o && ram_re_o);
  endproperty
  a_excl: assert property (p_excl) else $error("both enables high");
  property p_idle_quiet;
    @(posedge ref_clk_i) disable iff (rst_i)
      !busy_o |-> !ram_we_o && !ram_re_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("enable while idle");
  c_write: cover property (@(posedge ref_clk_i) disable iff (rst_i) $fell(ram_we_o));
  c_read: cover property (@(posedge ref_clk_i) disable iff (rst_i) rd_valid_o);
  c_wr_then_rd: cover property (@(posedge ref_clk_i) disable iff (rst_i)
    $fell(ram_we_o) ##[1:20] rd_valid_o);
endmodule

// ---- rtl/rtm_timer.sv ----
// down counter that times each phase of a device access
`timescale 1ns/1ps
module rtm_timer (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  rtm_tmr_if.tmr t
);
  logic [rtm_pkg::CNT_W-1:0] cnt;
  logic [rtm_pkg::CNT_W-1:0] next_cnt;
  wire at_zero = (cnt == rtm_pkg::CNT_ZERO);
  assign next_cnt = t.load ? t.count : (at_zero ? cnt : cnt - 8'h01);
  // done once the loaded phase has run out; it must not look at load, which the
  // sequencer forms from done, or the two would close a combinational loop
  assign t.done = at_zero;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt <= rtm_pkg::CNT_ZERO;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// ---- testbench/rtm_ram_model.sv ----
// behavioural ram answering the host's write and read sections
`timescale 1ns/1ps
module rtm_ram_model #(
  parameter logic [15:0] INIT_BITS = 16'ha5c3
) (
  input wire logic [rtm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [rtm_pkg::DATA_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [rtm_pkg::DATA_W-1:0] rdata_o
);
  // words never written or loaded stay unknown
  logic [rtm_pkg::DATA_W-1:0] mem [2**rtm_pkg::ADDR_W];
  logic [rtm_pkg::DATA_W-1:0] last;
  logic we_seen = 1'b0;
  initial begin
    for (int b = 0; b < $bits(INIT_BITS); b++) begin
      mem[b / rtm_pkg::DATA_W][b % rtm_pkg::DATA_W] = INIT_BITS[b];
    end
  end
  // the power-up fall from unknown to low is not a write and must not hit word zero
  always @(posedge we_i) we_seen <= 1'b1;
  always @(negedge we_i) if (we_seen) mem[addr_i] <= wdata_i;
  always_latch if (re_i) last <= mem[addr_i];
  // released pins show the inverse, so a stale sample cannot pass as data
  assign rdata_o = re_i ? mem[addr_i] : ~last;
endmodule

// ---- testbench/tb_rtm_host.sv ----
// self-checking bench for the ram timing host controller
`timescale 1ns/1ps
module tb_rtm_host;
  logic ref_clk_i = 0, rst_i = 1, wr_req_i = 0, rd_req_i = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, ram_rdata, rdata, ram_addr, ram_wdata;
  logic busy, rd_valid, ram_we, ram_re, we_q = 0;
  logic [7:0] a_q, d_q;
  int err_total = 0, tests_run = 0, hi_cnt = 0, lo_cnt = 9, stab = 0;
  rtm_host DUT (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_req_i(wr_req_i),
    .rd_req_i(rd_req_i), .addr_i(addr_i), .wdata_i(wdata_i), .ram_rdata_i(ram_rdata),
    .busy_o(busy), .rd_valid_o(rd_valid), .rdata_o(rdata), .ram_addr_o(ram_addr),
    .ram_wdata_o(ram_wdata), .ram_we_o(ram_we), .ram_re_o(ram_re));
  rtm_ram_model #(.INIT_BITS(16'ha5c3)) ram (.addr_i(ram_addr), .wdata_i(ram_wdata),
    .we_i(ram_we), .re_i(ram_re), .rdata_o(ram_rdata));
  initial forever #5 ref_clk_i = ~ref_clk_i;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // write strobe shape as seen on the device pins
  always @(posedge ref_clk_i) begin
    a_q <= ram_addr;
    d_q <= ram_wdata;
    stab <= (ram_addr !== a_q || ram_wdata !== d_q) ? 0 : stab + 1;
    we_q <= ram_we;
    if (ram_we && !we_q) begin
      check(8'(stab >= rtm_pkg::SU_CYC - 1), 8'h01);
      check(8'(lo_cnt >= rtm_pkg::LO_CYC), 8'h01);
    end
    if (ram_we || we_q) check(8'(ram_addr !== a_q || ram_wdata !== d_q), 8'h00);
    if (ram_we) check(8'(ram_re), 8'h00);
    hi_cnt <= ram_we ? hi_cnt + 1 : 0;
    lo_cnt <= ram_we ? 0 : lo_cnt + 1;
    if (!ram_we && we_q) check(8'(hi_cnt), 8'(rtm_pkg::HI_CYC));
  end
  task automatic wait_idle();
    int n;
    for (n = 0; n < 20 && busy !== 1'b0; n++) @(negedge ref_clk_i);
    check(8'(n < 20), 8'h01);
  endtask
  task automatic do_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk_i);
    addr_i = a;
    wdata_i = d;
    wr_req_i = 1;
    @(negedge ref_clk_i);
    wr_req_i = 0;
    wait_idle();
  endtask
  task automatic do_read(input logic [7:0] a, input logic [7:0] exp);
    int n;
    @(negedge ref_clk_i);
    addr_i = a;
    rd_req_i = 1;
    @(negedge ref_clk_i);
    rd_req_i = 0;
    for (n = 0; n < 10 && rd_valid !== 1'b1; n++) @(negedge ref_clk_i);
    check(8'(n < 10), 8'h01);
    check(rdata, exp);
    wait_idle();
  endtask
  task automatic t_init();
    do_read(8'h00, 8'hc3);
    do_read(8'h01, 8'ha5);
    $display("test init done");
  endtask
  task automatic t_rw();
    do_write(8'h10, 8'h3c);
    do_write(8'h11, 8'hc3);
    do_read(8'h10, 8'h3c);
    do_read(8'h11, 8'hc3);
    do_read(8'h10, 8'h3c);
    $display("test write read done");
  endtask
  task automatic t_refuse();
    @(negedge ref_clk_i);
    addr_i = 8'h30;
    wdata_i = 8'h66;
    wr_req_i = 1;
    @(negedge ref_clk_i);
    wr_req_i = 0;
    @(negedge ref_clk_i);
    addr_i = 8'h20;
    wr_req_i = 1;
    @(negedge ref_clk_i);
    wr_req_i = 0;
    wait_idle();
    do_read(8'h30, 8'h66);
    do_read(8'h20, 8'hxx);
    $display("test refuse done");
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (2) @(negedge ref_clk_i);
    rst_i = 0;
    check({busy, rd_valid, ram_we, ram_re, 4'h0}, 8'h00);
    t_init();
    t_rw();
    t_refuse();
    wrap_up();
  end
endmodule
